// [core/bmap_flash.sv]
// Purpose: code flash array with one write port and two read ports
// Assumes: reads are combinational, writes take effect at the edge
// Notes: no erase model; a write simply replaces the byte
`timescale 1ns/1ps
module bmap_flash #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] code_addr_i,
  output logic [DW-1:0] code_data_o,
  input wire logic [AW-1:0] data_addr_i,
  output logic [DW-1:0] data_data_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign code_data_o = mem[code_addr_i];
  assign data_data_o = mem[data_addr_i];
endmodule : bmap_flash

// [core/bmap_pkg.sv]
// Purpose: shared constants for the boot and code-memory map block
// Assumes: 16-bit code addresses, 8-bit register port
// Notes: offsets are register-port addresses
package bmap_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int REG_AW = 8;
  // code space regions
  localparam logic [15:0] ROM_LAST = 16'h07FF;
  localparam logic [15:0] STUB_FIRST = 16'hFFF7;
  localparam logic [15:0] STUB_LAST = 16'hFFFF;
  localparam logic [15:0] FLASH_LAST = 16'hFFFF;
  localparam logic [15:0] APP_START = 16'h0000;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // register offsets
  localparam logic [7:0] OFF_WAIT = 8'h92;
  localparam logic [7:0] OFF_CONF = 8'hFF;
  localparam logic [7:0] OFF_STATUS = 8'hB1;
  localparam logic [7:0] OFF_SWITCH = 8'hB2;
  // wrapper_configuration fields
  localparam int CONF_KEEP_BIT = 7;
  localparam int CONF_ISP_BIT = 6;
  localparam int CONF_EM_HI = 5;
  localparam int CONF_EM_LO = 3;
  localparam int CONF_RSVD_BIT = 2;
  localparam int CONF_BIT_ONE = 1;
  localparam int CONF_BIT_ZERO = 0;
  localparam logic [7:0] CONF_RESET = 8'h00;
  localparam logic [7:0] CONF_RSVD_MASK = 8'h04;
  localparam logic [7:0] WAIT_RESET = 8'h00;
  // status fields
  localparam int STAT_APP_BIT = 0;
  localparam int STAT_BOOTSEL_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_KEEP_BIT = 3;
  localparam int SWITCH_GO_BIT = 0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    BMAP_SRC_NONE = 2'b00,
    BMAP_SRC_ROM = 2'b01,
    BMAP_SRC_STUB = 2'b10,
    BMAP_SRC_FLASH = 2'b11
  } bmap_src_t;
endpackage : bmap_pkg

// [core/bmap_top.sv]
// Purpose: boot and code-memory map control with wait states and memory lock
// Assumes: boot rom and entry stub contents arrive combinationally from outside
// Notes: one clock, synchronous reset; register reads answer one cycle later
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module bmap_top #(
  parameter logic [7:0] WAIT_DEFAULT = bmap_pkg::WAIT_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic boot_select_pin_i,
  input wire logic mem_lock_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // code fetch port
  input wire logic fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  output logic fetch_ready_o,
  output logic [7:0] fetch_rdata_o,
  output logic fetch_fault_o,
  output logic pc_load_o,
  output logic [15:0] pc_target_o,
  // boot rom and entry stub contents
  output logic [15:0] rom_addr_o,
  input wire logic [7:0] rom_rdata_i,
  input wire logic [7:0] stub_rdata_i,
  // data-space flash port
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [15:0] data_addr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_rdata_o,
  // outside and debugger access
  input wire logic ext_req_i,
  output logic ext_grant_o,
  input wire logic dbg_req_i,
  output logic dbg_grant_o,
  // configuration outputs
  output logic boot_isp_o,
  output logic app_mode_o,
  output logic isp_enable_bit_o,
  output logic [2:0] ext_mem_mode_o,
  output logic [1:0] config_ctrl_o
);
  typedef enum logic [1:0] {
    BMAP_IDLE = 2'b00,
    BMAP_WAIT = 2'b01
  } bmap_fsm_t;

  function automatic logic in_rom(input logic [15:0] a);
    in_rom = (a <= bmap_pkg::ROM_LAST);
  endfunction : in_rom

  function automatic logic in_stub(input logic [15:0] a);
    in_stub = (a >= bmap_pkg::STUB_FIRST);
  endfunction : in_stub

  logic app_q;
  logic bootsel_q;
  logic [7:0] conf_q;
  logic [7:0] wait_q;
  logic [7:0] rdata_q;
  logic reset_seen_q;
  bmap_fsm_t state_q;
  logic ready_q;
  logic fault_q;
  logic [7:0] fdata_q;
  logic pc_load_q;
  logic [15:0] pc_target_q;
  logic [7:0] ddata_q;
  bmap_pkg::bmap_src_t src;
  logic [7:0] flash_code;
  logic [7:0] flash_data;
  logic wait_done;
  logic take;
  logic switch_go;
  logic conf_wr;
  logic flash_wr;

  // no take in the answer cycle: a core holding its request until it sees ready is not re-served
  assign take = (state_q == BMAP_IDLE) && fetch_req_i && !ready_q;
  assign conf_wr = reg_wr_i && (reg_addr_i == bmap_pkg::OFF_CONF);
  // the stub may switch the map only once per boot
  assign switch_go = reg_wr_i && (reg_addr_i == bmap_pkg::OFF_SWITCH)
                     && reg_wdata_i[bmap_pkg::SWITCH_GO_BIT] && !app_q;
  // flash is writable only while it lives in data space
  assign flash_wr = data_wr_i && !app_q;

  // code source decode for the current fetch address
  always_comb begin
    src = bmap_pkg::BMAP_SRC_NONE;
    if (!app_q) begin
      if (in_rom(fetch_addr_i)) begin
        src = bmap_pkg::BMAP_SRC_ROM;
      end else if (in_stub(fetch_addr_i)) begin
        src = bmap_pkg::BMAP_SRC_STUB;
      end
    end else if (conf_q[bmap_pkg::CONF_KEEP_BIT] && in_stub(fetch_addr_i)) begin
      src = bmap_pkg::BMAP_SRC_STUB;
    end else begin
      src = bmap_pkg::BMAP_SRC_FLASH;
    end
  end

  assign rom_addr_o = fetch_addr_i;

  bmap_flash #(
    .AW(bmap_pkg::ADDR_W),
    .DW(bmap_pkg::DATA_W)
  ) u_flash (
    .clk_i(clk_i),
    .wr_i(flash_wr),
    .waddr_i(data_addr_i),
    .wdata_i(data_wdata_i),
    .code_addr_i(fetch_addr_i),
    .code_data_o(flash_code),
    .data_addr_i(data_addr_i),
    .data_data_o(flash_data)
  );

  bmap_wait #(
    .W(8)
  ) u_wait (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(take),
    .count_i(wait_q),
    .step_i(state_q == BMAP_WAIT),
    .done_o(wait_done)
  );

  // map state: boot view after reset, application view after the switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      app_q <= 1'b0;
    end else if (switch_go) begin
      app_q <= 1'b1;
    end
  end

  // boot-select caught after reset release; only the boot rom acts on it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_seen_q <= 1'b0;
      bootsel_q <= 1'b0;
    end else if (!reset_seen_q) begin
      reset_seen_q <= 1'b1;
      bootsel_q <= boot_select_pin_i;
    end
  end

  // reset vector load, then the jump to flash start after the switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_q <= 1'b0;
      pc_target_q <= bmap_pkg::RESET_VECTOR;
    end else if (!reset_seen_q) begin
      pc_load_q <= 1'b1;
      pc_target_q <= bmap_pkg::RESET_VECTOR;
    end else if (switch_go) begin
      pc_load_q <= 1'b1;
      pc_target_q <= bmap_pkg::APP_START;
    end else begin
      pc_load_q <= 1'b0;
    end
  end

  // configuration register; the switch sets keep and wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conf_q <= bmap_pkg::CONF_RESET;
    end else begin
      if (conf_wr) begin
        conf_q <= reg_wdata_i & ~bmap_pkg::CONF_RSVD_MASK;
      end
      if (switch_go) begin
        conf_q[bmap_pkg::CONF_KEEP_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= WAIT_DEFAULT;
    end else if (reg_wr_i && reg_addr_i == bmap_pkg::OFF_WAIT) begin
      wait_q <= reg_wdata_i;
    end
  end

  // register read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= bmap_pkg::ZERO_BYTE;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        bmap_pkg::OFF_WAIT: rdata_q <= wait_q;
        bmap_pkg::OFF_CONF: rdata_q <= conf_q;
        bmap_pkg::OFF_STATUS: begin
          rdata_q <= {4'h0, conf_q[bmap_pkg::CONF_KEEP_BIT], mem_lock_i, bootsel_q, app_q};
        end
        default: rdata_q <= bmap_pkg::ZERO_BYTE;
      endcase
    end else begin
      rdata_q <= bmap_pkg::ZERO_BYTE;
    end
  end

  // fetch sequencer: exactly wait_q idle cycles before the answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BMAP_IDLE;
      ready_q <= 1'b0;
      fault_q <= 1'b0;
      fdata_q <= bmap_pkg::ZERO_BYTE;
    end else begin
      ready_q <= 1'b0;
      unique case (state_q)
        BMAP_IDLE: begin
          if (take) begin
            state_q <= BMAP_WAIT;
            fault_q <= 1'b0;
          end
        end
        BMAP_WAIT: begin
          if (wait_done) begin
            state_q <= BMAP_IDLE;
            ready_q <= 1'b1;
            fault_q <= (src == bmap_pkg::BMAP_SRC_NONE);
            unique case (src)
              bmap_pkg::BMAP_SRC_ROM: fdata_q <= rom_rdata_i;
              bmap_pkg::BMAP_SRC_STUB: fdata_q <= stub_rdata_i;
              bmap_pkg::BMAP_SRC_FLASH: fdata_q <= flash_code;
              bmap_pkg::BMAP_SRC_NONE: fdata_q <= bmap_pkg::ZERO_BYTE;
            endcase
          end
        end
        default: state_q <= BMAP_IDLE;
      endcase
    end
  end

  // data-space read of flash, only in the boot view
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ddata_q <= bmap_pkg::ZERO_BYTE;
    end else if (data_rd_i) begin
      ddata_q <= app_q ? bmap_pkg::ZERO_BYTE : flash_data;
    end
  end

  // lock is a plain level, so the refusal tracks it with no latency
  assign ext_grant_o = ext_req_i && !mem_lock_i;
  assign dbg_grant_o = dbg_req_i && !mem_lock_i;

  assign reg_rdata_o = rdata_q;
  assign fetch_ready_o = ready_q;
  assign fetch_rdata_o = fdata_q;
  assign fetch_fault_o = fault_q;
  assign pc_load_o = pc_load_q;
  assign pc_target_o = pc_target_q;
  assign data_rdata_o = ddata_q;
  assign boot_isp_o = bootsel_q;
  assign app_mode_o = app_q;
  assign isp_enable_bit_o = conf_q[bmap_pkg::CONF_ISP_BIT];
  assign ext_mem_mode_o = conf_q[bmap_pkg::CONF_EM_HI:bmap_pkg::CONF_EM_LO];
  assign config_ctrl_o = {conf_q[bmap_pkg::CONF_BIT_ONE], conf_q[bmap_pkg::CONF_BIT_ZERO]};

  // helper: cycles spent waiting in the current fetch
  logic [8:0] wcnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || take) begin
      wcnt_q <= 9'h000;
    end else if (state_q == BMAP_WAIT) begin
      wcnt_q <= wcnt_q + 9'h001;
    end
  end

  AST_BOOT_VIEW: assert property (@(posedge clk_i) $fell(rst_i) |-> !app_q)
    else $error("map not in boot view after reset");
  AST_RESET_VECTOR: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |=> pc_load_o && pc_target_o == 16'h0000)
    else $error("no reset vector load");
  AST_BOOTSEL: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(reset_seen_q) |-> boot_isp_o == $past(boot_select_pin_i))
    else $error("boot select not captured");
  AST_ROM_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
    !app_q && fetch_addr_i <= 16'h07FF |-> src == bmap_pkg::BMAP_SRC_ROM)
    else $error("rom not decoded in boot view");
  AST_NO_FLASH_FETCH: assert property (@(posedge clk_i) disable iff (rst_i)
    !app_q |-> src != bmap_pkg::BMAP_SRC_FLASH)
    else $error("flash fetched in boot view");
  AST_SWITCH_JUMP: assert property (@(posedge clk_i) disable iff (rst_i)
    switch_go |=> app_q && pc_load_o && pc_target_o == 16'h0000
    && conf_q[7])
    else $error("switch did not map flash and jump");
  AST_STUB_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
    app_q && !conf_q[7] |-> src == bmap_pkg::BMAP_SRC_FLASH)
    else $error("stub window still mapped");
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(conf_wr) && !$past(switch_go)
    |-> conf_q == ($past(reg_wdata_i) & 8'hFB))
    else $error("configuration write wrong");
  AST_WAIT_EXACT: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ready_q) |-> wcnt_q == {1'b0, $past(wait_q)} + 9'h001)
    else $error("wrong number of wait states");
  AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_lock_i |-> !ext_grant_o && !dbg_grant_o)
    else $error("access granted under lock");

  COV_APP: cover property (@(posedge clk_i) disable iff (rst_i) $rose(app_q));
  COV_FETCH_WAIT: cover property (@(posedge clk_i) disable iff (rst_i)
    take && wait_q == 8'h03 ##[1:10] ready_q);
  COV_KEEP_CLEAR: cover property (@(posedge clk_i) disable iff (rst_i)
    app_q && $fell(conf_q[7]));
endmodule : bmap_top

// [core/bmap_wait.sv]
// Purpose: wait-state down counter for one code fetch
// Assumes: load and step never coincide with an idle request
// Notes: done is high while the count has run out
`timescale 1ns/1ps
module bmap_wait #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  input wire logic step_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (step_i && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done_o = (cnt_q == '0);
endmodule : bmap_wait

// [sim/bmap_core_model.sv]
// Purpose: processor core model issuing code fetches to the map block
// Assumes: one fetch at a time, request held until the ready pulse
// Notes: released address shows the inverse so stale values never pass
`timescale 1ns/1ps
module bmap_core_model (
  input wire logic clk_i,
  input wire logic fetch_ready_i,
  input wire logic [7:0] fetch_rdata_i,
  input wire logic fetch_fault_i,
  output logic fetch_req_o,
  output logic [15:0] fetch_addr_o
);
  initial begin
    fetch_req_o = 1'b0;
    fetch_addr_o = 16'h0000;
  end

  // gap idles the core first, so slow requesters are covered too
  task automatic fetch(input logic [15:0] addr, input int gap, output logic [7:0] data,
                       output logic fault, output int edges);
    edges = 0;
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    fetch_req_o <= 1'b1;
    fetch_addr_o <= addr;
    do begin
      @(posedge clk_i);
      edges++;
    end while (fetch_ready_i !== 1'b1 && edges < 300);
    data = fetch_rdata_i;
    fault = fetch_fault_i;
    // dropped at the ready edge, else the block takes it again
    fetch_req_o <= 1'b0;
    fetch_addr_o <= ~addr;
  endtask : fetch
endmodule : bmap_core_model

// [sim/test_bmap_top.sv]
// Purpose: self-checking bench for the boot and code-memory map block
// Assumes: rom and stub contents are simple functions of the fetch address
// Notes: wait value is tracked here to predict the ready latency
`timescale 1ns/1ps
module test_bmap_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic boot_sel = 1'b0;
  logic lock = 1'b0;
  logic [7:0] r_addr = 8'h00;
  logic [7:0] r_wdata = 8'h00;
  logic r_wr = 1'b0;
  logic r_rd = 1'b0;
  logic [7:0] r_rdata;
  logic f_req;
  logic [15:0] f_addr;
  logic f_ready;
  logic [7:0] f_rdata;
  logic f_fault;
  logic pc_load;
  logic [15:0] pc_target;
  logic [15:0] rom_addr;
  logic [7:0] rom_rdata;
  logic [7:0] stub_rdata;
  logic d_wr = 1'b0;
  logic d_rd = 1'b0;
  logic [15:0] d_addr = 16'h0000;
  logic [7:0] d_wdata = 8'h00;
  logic [7:0] d_rdata;
  logic ext_req = 1'b0;
  logic ext_grant;
  logic dbg_req = 1'b0;
  logic dbg_grant;
  logic boot_isp;
  logic app_mode;
  logic isp_bit;
  logic [2:0] em_mode;
  logic [1:0] ctrl;
  int fails = 0;
  int n_tests = 0;
  int cur_wait = 0;
  logic [7:0] wt [3] = '{8'h01, 8'h03, 8'h07};

  always #10 clk_i = ~clk_i;
  assign rom_rdata = rom_addr[7:0] ^ 8'h3c;
  assign stub_rdata = ~rom_addr[7:0];

  bmap_top #(.WAIT_DEFAULT(8'h00)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .boot_select_pin_i(boot_sel), .mem_lock_i(lock), .reg_addr_i(r_addr),
    .reg_wdata_i(r_wdata), .reg_wr_i(r_wr), .reg_rd_i(r_rd), .reg_rdata_o(r_rdata),
    .fetch_req_i(f_req), .fetch_addr_i(f_addr), .fetch_ready_o(f_ready),
    .fetch_rdata_o(f_rdata), .fetch_fault_o(f_fault), .pc_load_o(pc_load),
    .pc_target_o(pc_target), .rom_addr_o(rom_addr), .rom_rdata_i(rom_rdata),
    .stub_rdata_i(stub_rdata), .data_wr_i(d_wr), .data_rd_i(d_rd), .data_addr_i(d_addr),
    .data_wdata_i(d_wdata), .data_rdata_o(d_rdata), .ext_req_i(ext_req),
    .ext_grant_o(ext_grant), .dbg_req_i(dbg_req), .dbg_grant_o(dbg_grant),
    .boot_isp_o(boot_isp), .app_mode_o(app_mode), .isp_enable_bit_o(isp_bit),
    .ext_mem_mode_o(em_mode), .config_ctrl_o(ctrl));

  bmap_core_model core (.clk_i(clk_i), .fetch_ready_i(f_ready), .fetch_rdata_i(f_rdata),
    .fetch_fault_i(f_fault), .fetch_req_o(f_req), .fetch_addr_o(f_addr));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic sel);
    @(posedge clk_i);
    rst_i <= 1'b1;
    boot_sel <= sel;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    cur_wait = 0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    r_wr <= 1'b1;
    r_addr <= a;
    r_wdata <= d;
    @(posedge clk_i);
    r_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    r_rd <= 1'b1;
    r_addr <= a;
    @(posedge clk_i);
    r_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), {8'h00, r_rdata}, {8'h00, exp});
  endtask : reg_read

  task automatic data_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    d_wr <= 1'b1;
    d_addr <= a;
    d_wdata <= d;
    @(posedge clk_i);
    d_wr <= 1'b0;
  endtask : data_write

  task automatic data_read(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    d_rd <= 1'b1;
    d_addr <= a;
    @(posedge clk_i);
    d_rd <= 1'b0;
    #1;
    check($sformatf("data %h", a), {8'h00, d_rdata}, {8'h00, exp});
  endtask : data_read

  task automatic fetch_chk(input logic [15:0] a, input logic [7:0] d, input logic f,
                           input int gap);
    logic [7:0] data;
    logic fault;
    int edges;
    core.fetch(a, gap, data, fault, edges);
    check($sformatf("fetch data %h", a), {8'h00, data}, {8'h00, d});
    check($sformatf("fetch fault %h", a), {15'h0000, fault}, {15'h0000, f});
    // take edge, wait states, answer edge, then the edge that samples ready
    check("fetch latency", 16'(edges), 16'(cur_wait + 3));
  endtask : fetch_chk

  initial begin
    #(20 * 5000);
    fails++;
    complete_run();
  end

  initial begin
    do_reset(1'b0);
    reg_read(bmap_pkg::OFF_CONF, 8'h00);
    reg_read(bmap_pkg::OFF_WAIT, 8'h00);
    reg_read(bmap_pkg::OFF_STATUS, 8'h00);
    reg_read(8'h10, 8'h00);
    check("app mode", {15'h0000, app_mode}, 16'h0000);
    fetch_chk(16'h0000, 8'h3c, 1'b0, 0);
    fetch_chk(16'h07ff, 8'hc3, 1'b0, 0);
    fetch_chk(16'h0800, 8'h00, 1'b1, 2);
    fetch_chk(16'hfff6, 8'h00, 1'b1, 0);
    fetch_chk(16'hfff7, 8'h08, 1'b0, 0);
    data_write(16'h0000, 8'h11);
    data_write(16'h0800, 8'h77);
    data_write(16'hfff8, 8'h99);
    data_read(16'h0800, 8'h77);
    for (int i = 0; i < 3; i++) begin
      reg_write(bmap_pkg::OFF_WAIT, wt[i]);
      cur_wait = int'(wt[i]);
      reg_read(bmap_pkg::OFF_WAIT, wt[i]);
      fetch_chk(16'h0000, 8'h3c, 1'b0, 0);
    end
    reg_write(bmap_pkg::OFF_WAIT, 8'h00);
    cur_wait = 0;
    reg_write(bmap_pkg::OFF_CONF, 8'h7e);
    reg_read(bmap_pkg::OFF_CONF, 8'h7a);
    check("config fields", {10'h000, isp_bit, em_mode, ctrl}, 16'h003e);
    reg_write(bmap_pkg::OFF_CONF, 8'h00);
    reg_write(bmap_pkg::OFF_SWITCH, 8'h01);
    #1;
    check("pc load", {15'h0000, pc_load}, 16'h0001);
    check("app mode", {15'h0000, app_mode}, 16'h0001);
    check("pc target", pc_target, 16'h0000);
    reg_read(bmap_pkg::OFF_CONF, 8'h80);
    reg_read(bmap_pkg::OFF_STATUS, 8'h09);
    fetch_chk(16'h0000, 8'h11, 1'b0, 0);
    fetch_chk(16'h0800, 8'h77, 1'b0, 1);
    fetch_chk(16'hfff8, 8'h07, 1'b0, 0);
    data_read(16'h0800, 8'h00);
    // startup code drops the stub window with a masked write-back
    reg_write(bmap_pkg::OFF_CONF, 8'h80 & 8'h7f);
    reg_read(bmap_pkg::OFF_CONF, 8'h00);
    fetch_chk(16'hfff8, 8'h99, 1'b0, 0);
    @(posedge clk_i);
    lock <= 1'b1;
    ext_req <= 1'b1;
    dbg_req <= 1'b1;
    @(posedge clk_i);
    #1;
    check("grants locked", {14'h0000, ext_grant, dbg_grant}, 16'h0000);
    reg_read(bmap_pkg::OFF_STATUS, 8'h05);
    @(posedge clk_i);
    lock <= 1'b0;
    #1;
    check("grants open", {14'h0000, ext_grant, dbg_grant}, 16'h0003);
    do_reset(1'b1);
    reg_read(bmap_pkg::OFF_STATUS, 8'h02);
    check("boot isp", {15'h0000, boot_isp}, 16'h0001);
    check("app mode", {15'h0000, app_mode}, 16'h0000);
    fetch_chk(16'h0000, 8'h3c, 1'b0, 0);
    fetch_chk(16'hfff8, 8'h07, 1'b0, 0);
    reg_read(bmap_pkg::OFF_CONF, 8'h00);
    complete_run();
  end
endmodule : test_bmap_top
